/* src/seq_pkg.sv */
// Overview of operation
// R1 - Three working modes: normal, command, diagnostic
// R2 - Power-on hold 500us to 2ms, pin tri-stated
// R3 - Durations scale inversely with oscillator rate
// R4 - Config readout and signature check, about 200us
// R5 - Start routine lasts five conversion times
// R6 - Startup error enters diagnostic, pin low range
// R7 - Then run cycle; window mode waits window
// R8 - Compute 16-bit correction per measurement signal
// R9 - Remove offset, temperature drift, third-order nonlinearity
// R10 - Result is non-negative 15-bit fraction
// R11 - Clip analog value to programmed limits
// R12 - Output mode from config or command
// R13 - One-wire-only: analog off, readout allowed
// R14 - Window mode: command accepted within 500ms window
// R15 - Analog-shared: output at once, window accepts command
// R16 - One-wire-disabled: analog on, readout rejected
// R17 - Any failure enters diagnostic, pin low range; POR_HOLD does not act on failures
// R18 - Diagnostic reads return error code
// R19 - Watchdog and oscillator failures are reported
// R20 - Memory and register parity errors are failures
// R21 - Sensor open or short is a failure
// R22 - Optional temperature sensor check flags failure
// R23 - Conversion time is 2^res over half oscillator
// R24 - Window starts at startup end, command cancels
package seq_pkg;
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned OSC_REF_HZ    = 3_000_000;
  localparam int unsigned POR_MIN_US    = 500;
  localparam int unsigned POR_MAX_US    = 2000;
  localparam int unsigned CFG_US        = 200;
  localparam int unsigned WINDOW_MS     = 500;
  localparam int unsigned START_CONV    = 5;
  localparam longint unsigned POR_CYC   =
    (longint'(POR_MIN_US) * CLK_HZ + 999_999) / 1_000_000;
  localparam longint unsigned CFG_CYC   =
    longint'(CFG_US) * CLK_HZ / 1_000_000;
  localparam longint unsigned WIN_CYC   =
    longint'(WINDOW_MS) * CLK_HZ / 1_000;
  // Conversion time in clock cycles: 2^res * 2 / f_osc
  localparam longint unsigned CONV13_CYC =
    (longint'(1) << 14) * CLK_HZ / OSC_REF_HZ;
  localparam longint unsigned CONV14_CYC =
    (longint'(1) << 15) * CLK_HZ / OSC_REF_HZ;
  localparam int unsigned CNT_W = 32;

  // APB map
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_LIMITS = 12'h008;
  localparam logic [11:0] ADDR_RESULT = 12'h00C;
  localparam logic [11:0] ADDR_RAW    = 12'h010;
  localparam logic [11:0] ADDR_FAIL   = 12'h014;
  // CTRL fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_RES_BIT  = 2;
  localparam int unsigned CTRL_TCHK_BIT = 3;
  localparam int unsigned CTRL_CMD_BIT  = 4;
  localparam int unsigned CTRL_EXIT_BIT = 5;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] LIMITS_RESET  = 32'h7FFF_0000;
  localparam logic [14:0] ERROR_CODE    = 15'h7FFF;
  localparam logic [15:0] DIAG_LEVEL    = 16'h0000;
  localparam int unsigned FAIL_W        = 7;

  typedef enum logic [1:0] {
    ANALOG_SHARED_MODE, WINDOW_MODE, ONE_WIRE_ONLY_MODE,
    ONE_WIRE_DISABLED_MODE
  } out_mode_type;

  typedef enum {
    POR_HOLD, CFG_READ, START_RUN, NORMAL_OPERATION,
    COMMAND_STATE, DIAGNOSTIC_STATE
  } seq_state_type;
endpackage

/* src/conditioner_mode_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
module conditioner_mode_sequencer
  import seq_pkg::*;
#(
  parameter longint unsigned POR_CYCLES  = seq_pkg::POR_CYC,
  parameter longint unsigned CFG_CYCLES  = seq_pkg::CFG_CYC,
  parameter longint unsigned WIN_CYCLES  = seq_pkg::WIN_CYC,
  parameter longint unsigned CONV13      = seq_pkg::CONV13_CYC,
  parameter longint unsigned CONV14      = seq_pkg::CONV14_CYC
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [1:0]           cfg_mode,
  input  wire logic                 cfg_signature_ok,
  input  wire logic                 enter_command_mode_cmd,
  input  wire logic                 one_wire_read_req,
  input  wire logic                 sample_valid,
  input  wire logic [15:0]          sample_raw,
  input  wire logic [15:0]          coef_offset,
  input  wire logic [15:0]          coef_gain,
  input  wire logic [15:0]          coef_temp,
  input  wire logic [15:0]          coef_cubic,
  input  wire logic [15:0]          temp_raw,
  input  wire logic                 watchdog_fail,
  input  wire logic                 osc_fail,
  input  wire logic                 memory_fail,
  input  wire logic                 parity_fail,
  input  wire logic                 sensor_open,
  input  wire logic                 sensor_short,
  input  wire logic                 temp_sensor_fail,
  output logic      [15:0]          output_pin,
  output logic                      output_pin_oe_n,
  output logic      [14:0]          one_wire_data,
  output logic                      one_wire_data_valid,
  output logic                      one_wire_reject,
  output logic      [2:0]           work_mode
);
  import seq_pkg::*;

  // ----------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------
  seq_state_type             state;
  logic [CNT_W-1:0]          count;
  logic [CNT_W-1:0]          win_count;
  logic                      win_open;
  logic [31:0]               ctrl;
  logic [31:0]               limits;
  logic [FAIL_W-1:0]         fail_sticky;
  logic [14:0]               result;
  logic [15:0]               correction;
  out_mode_type              mode;
  logic                      startup_err;
  logic [FAIL_W-1:0]         fail_now;
  logic                      any_fail;
  logic [CNT_W-1:0]          conv_cyc;
  logic                      apb_wr;
  logic                      apb_rd;
  logic [15:0]               cond_x;
  logic [15:0]               cond_x3;
  logic [16:0]               cond_acc;
  logic [14:0]               lim_lo;
  logic [14:0]               lim_hi;

  function automatic logic [15:0] mul_q15(input logic [15:0] a,
                                          input logic [15:0] b);
    logic [31:0] p;
    p = a * b;
    return p[30:15];
  endfunction

  // ----------------------------------------------------------
  // Failure collection
  // ----------------------------------------------------------
  always_comb begin
    fail_now = {watchdog_fail, osc_fail, memory_fail, parity_fail,
                sensor_open, sensor_short,
                temp_sensor_fail & ctrl[CTRL_TCHK_BIT]}; // R19 R20 R21 R22
    any_fail = |fail_now;
    conv_cyc = ctrl[CTRL_RES_BIT] ? CNT_W'(CONV14) : CNT_W'(CONV13); // R23 R3
    startup_err = (state == CFG_READ) && (count == '0)
                  && !cfg_signature_ok;
  end

  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign lim_lo = limits[14:0];
  assign lim_hi = limits[30:16];

  // ----------------------------------------------------------
  // Mode and control registers
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= CTRL_RESET;
      limits <= LIMITS_RESET;
    end else if (apb_wr && paddr == ADDR_CTRL) begin
      ctrl <= pwdata;
    end else if (apb_wr && paddr == ADDR_LIMITS) begin
      limits <= pwdata;
    end else begin
      ctrl[CTRL_CMD_BIT]  <= 1'b0;
      ctrl[CTRL_EXIT_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mode <= ANALOG_SHARED_MODE;
    else if (state == CFG_READ && count == '0)
      mode <= out_mode_type'(cfg_mode); // R12
    else if (apb_wr && paddr == ADDR_CTRL)
      mode <= out_mode_type'(pwdata[CTRL_MODE_LSB +: 2]); // R12
  end

  // ----------------------------------------------------------
  // Startup sequencer
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= POR_HOLD;
      count <= CNT_W'(POR_CYCLES - 1);
    end else begin
      case (state) // R1
        POR_HOLD: begin // R2
          if (count == '0) begin
            state <= CFG_READ;
            count <= CNT_W'(CFG_CYCLES - 1);
          end else
            count <= count - 1'b1;
        end
        CFG_READ: begin // R4
          if (startup_err || any_fail)
            state <= DIAGNOSTIC_STATE; // R6
          else if (count == '0) begin
            state <= START_RUN;
            count <= CNT_W'(START_CONV) * conv_cyc - 1'b1; // R5
          end else
            count <= count - 1'b1;
        end
        START_RUN: begin
          if (any_fail)
            state <= DIAGNOSTIC_STATE; // R6
          else if (count == '0)
            state <= NORMAL_OPERATION; // R7
          else
            count <= count - 1'b1;
        end
        NORMAL_OPERATION: begin
          if (any_fail)
            state <= DIAGNOSTIC_STATE; // R17
          else if ((enter_command_mode_cmd && win_open)
                   || ctrl[CTRL_CMD_BIT])
            state <= COMMAND_STATE; // R14 R15
        end
        COMMAND_STATE: begin
          if (any_fail)
            state <= DIAGNOSTIC_STATE;
          else if (ctrl[CTRL_EXIT_BIT])
            state <= NORMAL_OPERATION;
        end
        DIAGNOSTIC_STATE: state <= DIAGNOSTIC_STATE;
        default: state <= DIAGNOSTIC_STATE;
      endcase
    end
  end

  // ----------------------------------------------------------
  // One-wire startup window
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_open  <= 1'b0;
      win_count <= '0;
    end else if (state == START_RUN && count == '0 && !any_fail
                 && (mode == WINDOW_MODE
                     || mode == ANALOG_SHARED_MODE)) begin
      win_open  <= 1'b1; // R24
      win_count <= CNT_W'(WIN_CYCLES - 1);
    end else if (win_open) begin
      if (enter_command_mode_cmd || win_count == '0
          || state != NORMAL_OPERATION)
        win_open <= 1'b0; // R24 R14
      else
        win_count <= win_count - 1'b1;
    end
  end

  // ----------------------------------------------------------
  // Conditioning calculation
  // ----------------------------------------------------------
  always_comb begin
    cond_x   = sample_raw - coef_offset - mul_q15(coef_temp, temp_raw); // R9
    cond_x3  = mul_q15(mul_q15(cond_x, cond_x), cond_x);
    cond_acc = {1'b0, mul_q15(cond_x, coef_gain)}
               + {1'b0, mul_q15(cond_x3, coef_cubic)};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      correction <= '0;
      result     <= '0;
    end else if (sample_valid && state == NORMAL_OPERATION) begin
      correction <= cond_acc[15:0]; // R8
      // Saturate rather than wrap so the fraction stays below one
      result <= (cond_acc[16] | cond_acc[15]) ? '1 : cond_acc[14:0]; // R10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      fail_sticky <= '0;
    else if (apb_wr && paddr == ADDR_FAIL)
      fail_sticky <= (fail_sticky & ~pwdata[FAIL_W-1:0]) | fail_now;
    else
      fail_sticky <= fail_sticky | fail_now;
  end

  // ----------------------------------------------------------
  // Output pin and one-wire readout
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_pin      <= DIAG_LEVEL;
      output_pin_oe_n <= 1'b1;
    end else begin
      output_pin <= DIAG_LEVEL;
      case (state)
        POR_HOLD: output_pin_oe_n <= 1'b1; // R2
        CFG_READ: output_pin_oe_n <= 1'b0; // R4
        START_RUN: output_pin_oe_n <= (mode == WINDOW_MODE
                       || mode == ONE_WIRE_ONLY_MODE); // R5
        NORMAL_OPERATION: begin
          output_pin_oe_n <= (mode == ONE_WIRE_ONLY_MODE)
                     || (mode == WINDOW_MODE && win_open); // R13 R7
          output_pin <= {1'b0, result < lim_lo ? lim_lo
                         : result > lim_hi ? lim_hi : result}; // R11
        end
        COMMAND_STATE: output_pin_oe_n <= 1'b1;
        default: output_pin_oe_n <= 1'b0; // R17
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      one_wire_data       <= '0;
      one_wire_data_valid <= 1'b0;
      one_wire_reject     <= 1'b0;
    end else begin
      one_wire_data_valid <= 1'b0;
      one_wire_reject     <= 1'b0;
      if (one_wire_read_req) begin
        if (mode == ONE_WIRE_DISABLED_MODE)
          one_wire_reject <= 1'b1; // R16
        else begin
          one_wire_data_valid <= 1'b1; // R13
          one_wire_data <= (state == DIAGNOSTIC_STATE) ? ERROR_CODE
                           : result; // R18
        end
      end
    end
  end

  always_comb begin
    work_mode = {state == DIAGNOSTIC_STATE, state == COMMAND_STATE,
                 state == NORMAL_OPERATION};
  end

  // ----------------------------------------------------------
  // APB read mux
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CTRL:   prdata <= ctrl;
        ADDR_STATUS: prdata <= {25'h0, win_open, mode, work_mode,
                                output_pin_oe_n};
        ADDR_LIMITS: prdata <= limits;
        ADDR_RESULT: prdata <= {17'h0, state == DIAGNOSTIC_STATE
                                ? ERROR_CODE : result}; // R18
        ADDR_RAW:    prdata <= {16'h0, correction};
        ADDR_FAIL:   prdata <= {25'h0, fail_sticky};
        default:     prdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  diag_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    (any_fail && state != POR_HOLD) |=> state == DIAGNOSTIC_STATE) // R17
    else $error("failure did not enter diagnostic");
  diag_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == DIAGNOSTIC_STATE |=> !output_pin_oe_n
      && output_pin == DIAG_LEVEL) // R6
    else $error("diagnostic pin level wrong");
  por_hiz_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == POR_HOLD |=> output_pin_oe_n) // R2
    else $error("pin driven during power-on hold");
  diag_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (one_wire_read_req && state == DIAGNOSTIC_STATE
     && mode != ONE_WIRE_DISABLED_MODE)
      |=> one_wire_data == ERROR_CODE && one_wire_data_valid) // R18
    else $error("no error code in diagnostic");
  reject_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (one_wire_read_req && mode == ONE_WIRE_DISABLED_MODE
     && $stable(mode)) |=> one_wire_reject && !one_wire_data_valid) // R16
    else $error("readout not rejected");
  clip_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(state) == NORMAL_OPERATION && state == NORMAL_OPERATION
      |-> output_pin[14:0] >= $past(limits[14:0])
          || $past(limits[14:0]) > $past(limits[30:16])) // R11
    else $error("output below lower limit");
  window_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == NORMAL_OPERATION && win_open && enter_command_mode_cmd
     && !any_fail) |=> state == COMMAND_STATE ##1 !win_open) // R14 R24
    else $error("command in window not taken");
  only_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == NORMAL_OPERATION && mode == ONE_WIRE_ONLY_MODE
      |=> output_pin_oe_n) // R13
    else $error("analog driven in one-wire-only mode");
  diag_stay_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == DIAGNOSTIC_STATE |=> state == DIAGNOSTIC_STATE) // R1
    else $error("diagnostic state left");
  reg_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == NORMAL_OPERATION && ctrl[CTRL_CMD_BIT] && !any_fail)
      |=> state == COMMAND_STATE) // R1
    else $error("register command not taken");
  cmd_hiz_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == COMMAND_STATE |=> output_pin_oe_n) // R1
    else $error("pin driven in command state");
  cfg_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == CFG_READ |=> !output_pin_oe_n
      && output_pin == DIAG_LEVEL) // R4
    else $error("config stage pin level wrong");
  start_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == START_RUN && (mode == ANALOG_SHARED_MODE
     || mode == ONE_WIRE_DISABLED_MODE))
      |=> !output_pin_oe_n && output_pin == DIAG_LEVEL) // R5
    else $error("start stage pin not in low range");
  start_hiz_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == START_RUN && (mode == WINDOW_MODE
     || mode == ONE_WIRE_ONLY_MODE)) |=> output_pin_oe_n) // R5
    else $error("start stage pin not tri-stated");
  window_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == NORMAL_OPERATION && mode == WINDOW_MODE && win_open)
      |=> output_pin_oe_n) // R7 R14
    else $error("analog driven inside window");
  disabled_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == NORMAL_OPERATION && mode == ONE_WIRE_DISABLED_MODE)
      |=> !output_pin_oe_n) // R16
    else $error("analog off in one-wire-disabled mode");
  clip_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(state) == NORMAL_OPERATION && state == NORMAL_OPERATION
      |-> output_pin[14:0] <= $past(limits[30:16])
          || $past(limits[14:0]) > $past(limits[30:16])) // R11
    else $error("output above upper limit");
  sticky_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|fail_now) |=> (fail_sticky & $past(fail_now))
      == $past(fail_now)) // R19 R20
    else $error("failure not recorded");
endmodule
`default_nettype wire

/* sim/one_wire_master.sv */
`timescale 1ns/1ns
`default_nettype none
module one_wire_master (
  input  wire logic pclk,
  output logic      enter_command_mode_cmd,
  output logic      one_wire_read_req,
  input  wire logic one_wire_data_valid,
  input  wire logic one_wire_reject
);
  // ------------------------------------------------
  // Calibration master frames
  // ------------------------------------------------
  initial begin
    enter_command_mode_cmd = 1'b0;
    one_wire_read_req = 1'b0;
  end

  // Single command frame; sent only when the bench asks for one
  task automatic send_command();
    @(posedge pclk) enter_command_mode_cmd <= 1'b1;
    @(posedge pclk) enter_command_mode_cmd <= 1'b0;
  endtask

  // Bit 0: data returned, bit 1: request refused
  task automatic read_data(output logic [1:0] ans);
    ans = 2'b00;
    @(posedge pclk) one_wire_read_req <= 1'b1;
    @(posedge pclk) one_wire_read_req <= 1'b0;
    repeat (4) begin
      #1;
      if (one_wire_data_valid === 1'b1) ans[0] = 1'b1;
      if (one_wire_reject === 1'b1) ans[1] = 1'b1;
      @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

/* sim/tb_conditioner_mode_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_conditioner_mode_sequencer;
  import seq_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr;
  logic [1:0]  cfg_mode;
  logic        sig_ok, cmd, rreq, sv, owv, owr, oe_n;
  logic [15:0] raw, c_off, c_gain, c_temp, c_cub, t_raw, pin;
  logic [14:0] owd;
  logic [6:0]  fv;
  logic [2:0]  work_mode;
  logic [31:0] exp_q[$];
  logic [1:0]  ans;
  int          n_fail, checked;

  // Short counts keep the whole run to about a thousand cycles
  conditioner_mode_sequencer #(.POR_CYCLES(10), .CFG_CYCLES(10),
    .WIN_CYCLES(50), .CONV13(4), .CONV14(8)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cfg_mode,
    .cfg_signature_ok(sig_ok), .enter_command_mode_cmd(cmd),
    .one_wire_read_req(rreq), .sample_valid(sv), .sample_raw(raw),
    .coef_offset(c_off), .coef_gain(c_gain), .coef_temp(c_temp),
    .coef_cubic(c_cub), .temp_raw(t_raw), .watchdog_fail(fv[0]),
    .osc_fail(fv[1]), .memory_fail(fv[2]), .parity_fail(fv[3]),
    .sensor_open(fv[4]), .sensor_short(fv[5]),
    .temp_sensor_fail(fv[6]), .output_pin(pin),
    .output_pin_oe_n(oe_n), .one_wire_data(owd),
    .one_wire_data_valid(owv), .one_wire_reject(owr), .work_mode);

  one_wire_master mst (.pclk, .enter_command_mode_cmd(cmd),
    .one_wire_read_req(rreq), .one_wire_data_valid(owv),
    .one_wire_reject(owr));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------
  task automatic fail(input string m);
    n_fail++;
    $display("Error at %0t: %s", $time, m);
  endtask

  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) fail(m);
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail("bus timeout");
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // Read data is taken at the edge that completes the access
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      checked++;
      if (exp_q.size() == 0) fail("unexpected read");
      else if (prdata !== exp_q.pop_front()) fail("read data");
      if (pslverr !== 1'b0) fail("slave error");
    end
  end

  task automatic wait_mode(input logic [2:0] m, input int lim);
    int n;
    n = 0;
    while (work_mode !== m && n < lim) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (work_mode !== m) begin
      fail("mode wait");
      stop_test();
    end
  endtask

  // Samples each startup stage in its middle, clear of boundaries
  task automatic rst(input out_mode_type m, input logic ok,
                     input logic r);
    @(posedge pclk);
    presetn <= 1'b0;
    cfg_mode <= m;
    sig_ok <= ok;
    fv <= 7'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Resolution bit must be set before the start run begins
    if (r) apb(1'b1, ADDR_CTRL, 32'h0000_0004);
    repeat (r ? 2 : 5) @(posedge pclk);
    #1 chk(oe_n === 1'b1 && pin === 16'h0000, "hold pin");
    repeat (10) @(posedge pclk);
    #1 chk(oe_n === 1'b0 && pin === 16'h0000, "config pin");
    repeat (15) @(posedge pclk);
    #1 chk(oe_n === (m == WINDOW_MODE || m == ONE_WIRE_ONLY_MODE),
      "start pin");
  endtask

  always @(posedge pclk) begin
    sv <= ($urandom % 8) == 0;
    raw <= 16'($urandom);
    t_raw <= 16'($urandom);
  end

  initial begin
    repeat (100000) @(posedge pclk);
    fail("run timeout");
    stop_test();
  end

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cfg_mode = 2'h0;
    sig_ok = 1'b1;
    fv = 7'h00;
    sv = 1'b0;
    raw = 16'h0;
    t_raw = 16'h0;
    n_fail = 0;
    checked = 0;
    void'($urandom(40391));
    c_off = 16'($urandom);
    c_gain = 16'($urandom);
    c_temp = 16'($urandom);
    c_cub = 16'($urandom);
    rst(ANALOG_SHARED_MODE, 1'b1, 1'b0);
    wait_mode(3'b001, 100);
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_LIMITS, LIMITS_RESET);
    apb(1'b1, ADDR_LIMITS, 32'h0200_0100);
    rd(ADDR_LIMITS, 32'h0200_0100);
    repeat (20) @(posedge pclk);
    #1 chk(pin >= 16'h0100 && pin <= 16'h0200, "clip range");
    rd(12'h020, 32'h0000_0000);
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    mst.read_data(ans);
    chk(ans === 2'b10, "mode by command");
    for (int i = 0; i < 4; i++) begin
      rst(out_mode_type'(i), 1'b1, 1'b0);
      wait_mode(3'b001, 100);
      case (i)
        0: begin
          chk(oe_n === 1'b0, "shared pin off");
          mst.send_command();
          repeat (3) @(posedge pclk);
          #1 chk(work_mode === 3'b010, "no command state");
        end
        1: begin
          chk(oe_n === 1'b1, "early output");
          repeat (60) @(posedge pclk);
          #1 chk(oe_n === 1'b0, "window never ended");
          mst.send_command();
          repeat (3) @(posedge pclk);
          #1 chk(work_mode === 3'b001, "late command taken");
        end
        2: begin
          repeat (60) @(posedge pclk);
          #1 chk(oe_n === 1'b1, "output driven");
          mst.read_data(ans);
          chk(ans === 2'b01, "readout missing");
        end
        default: begin
          chk(oe_n === 1'b0, "disabled pin off");
          mst.read_data(ans);
          chk(ans === 2'b10, "readout not refused");
          apb(1'b1, ADDR_CTRL, 32'h0000_0013);
          repeat (2) @(posedge pclk);
          #1 chk(work_mode === 3'b010 && oe_n === 1'b1, "reg command");
          apb(1'b1, ADDR_CTRL, 32'h0000_0023);
          repeat (2) @(posedge pclk);
          #1 chk(work_mode === 3'b001, "command exit");
        end
      endcase
    end
    for (int i = 0; i < 7; i++) begin
      rst(ANALOG_SHARED_MODE, 1'b1, 1'b0);
      wait_mode(3'b001, 100);
      if (i == 6) apb(1'b1, ADDR_CTRL, 32'h0000_0008);
      @(posedge pclk);
      fv <= 7'(1 << i);
      wait_mode(3'b100, 10);
      @(posedge pclk);
      #1 chk(pin === 16'h0000 && oe_n === 1'b0, "fail pin");
      rd(ADDR_RESULT, {17'h0, ERROR_CODE});
      mst.read_data(ans);
      chk(ans === 2'b01 && owd === ERROR_CODE, "diag readout");
      fv <= 7'h00;
      apb(1'b1, ADDR_FAIL, 32'h0000_007F);
      rd(ADDR_FAIL, 32'h0000_0000);
    end
    rst(ANALOG_SHARED_MODE, 1'b1, 1'b1);
    repeat (25) @(posedge pclk);
    #1 chk(work_mode === 3'b000, "start run too short");
    wait_mode(3'b001, 10);
    rst(ANALOG_SHARED_MODE, 1'b0, 1'b0);
    wait_mode(3'b100, 60);
    chk(pin === 16'h0000 && oe_n === 1'b0, "startup error pin");
    stop_test();
  end
endmodule
`default_nettype wire
